// file: rtl/esmd_consts.svh
// How it works
// - With global and high enables set, high window maps to DRAM A0000h-BFFFFh.
// - Non-management touch of high region or top segment, open clear, sets bit 6.
// - Bits 5, 4 and 3 always read one; writes never change them.
// - Enabled top segment is not claimed for normal accesses; forwarded to hub.
// - Top segment is management memory only with global enable and bit 0 set.
// - Once locked, bit 7, size field and segment enable ignore writes.
// - Control register sits at offset 9Eh and resets to 38h.
// - Global enable, bit 3 of neighbour register, gates remap and segment claim; segment enable alone still forwards the top segment to hub.
// - Lock comes in on mgmtConfigLock; this block never sets or clears it.
// - Open set with lock clear shows management DRAM outside management mode.
`ifndef ESMD_CONSTS_SVH
`define ESMD_CONSTS_SVH
`define ESMD_CTRL_OFS     8'h9E
`define ESMD_CTRL_RST     8'h38
`define ESMD_HIGH_RST     1'b0
`define ESMD_ERR_RST      1'b0
`define ESMD_SZ_RST       2'b00
`define ESMD_TEN_RST      1'b0
`define ESMD_HIGH_BIT     7
`define ESMD_ERR_BIT      6
`define ESMD_FIXED_MASK   8'h38
`define ESMD_SZ_HI        2
`define ESMD_SZ_LO        1
`define ESMD_TEN_BIT      0
`define ESMD_HIGH_BASE    32'hFEDA_0000
`define ESMD_HIGH_LAST    32'hFEDB_FFFF
`define ESMD_LEGACY_BASE  32'h000A_0000
`define ESMD_LEGACY_LAST  32'h000B_FFFF
`define ESMD_SZ_128K      32'h0002_0000
`define ESMD_SZ_256K      32'h0004_0000
`define ESMD_SZ_512K      32'h0008_0000
`define ESMD_SZ_1M        32'h0010_0000
`endif

// file: rtl/esmd_pkg.sv
package esmd_pkg;
	typedef logic [1:0] esmd_size_t;
endpackage

// file: rtl/extended_smram_decode_control.sv
`timescale 1ns/1ps
`include "esmd_consts.svh"
module extended_smram_decode_control
	import esmd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        cfgWrEn,
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [7:0]  cfgWrData,
	output logic      [7:0]  cfgRdData,
	input  wire logic        globalMgmtMemEnable,
	input  wire logic        mgmtConfigLock,
	input  wire logic        mgmtOpen,
	input  wire logic [31:0] topOfMemory,
	input  wire logic        hostValid,
	input  wire logic [31:0] hostAddr,
	input  wire logic        hostMgmtMode,
	output logic             dramClaim,
	output logic             hubForward,
	output logic      [31:0] dramAddr
);
	logic       highEnable_r, highEnable_nxt;
	logic       errFlag_r, errFlag_nxt;
	esmd_size_t segSize_r, segSize_nxt;
	logic       segEnable_r, segEnable_nxt;
	logic [31:0] segBytes, segBase;
	logic       inHigh, inSeg, highOn, segOn, mgmtSees, wrHit;

	assign wrHit = cfgWrEn && (cfgAddr == `ESMD_CTRL_OFS);

	always_comb
	begin
		unique case (segSize_r)
			2'b00: segBytes = `ESMD_SZ_128K;
			2'b01: segBytes = `ESMD_SZ_256K;
			2'b10: segBytes = `ESMD_SZ_512K;
			2'b11: segBytes = `ESMD_SZ_1M;
		endcase
	end
	assign segBase  = topOfMemory - segBytes;
	assign inHigh   = (hostAddr >= `ESMD_HIGH_BASE) && (hostAddr <= `ESMD_HIGH_LAST);
	assign inSeg    = (hostAddr >= segBase) && (hostAddr < topOfMemory);
	assign highOn   = globalMgmtMemEnable && highEnable_r;
	assign segOn    = globalMgmtMemEnable && segEnable_r;
	assign mgmtSees = hostMgmtMode || (mgmtOpen && !mgmtConfigLock);

	always_comb
	begin
		highEnable_nxt = highEnable_r;
		segSize_nxt    = segSize_r;
		segEnable_nxt  = segEnable_r;
		errFlag_nxt    = errFlag_r;
		if (wrHit && !mgmtConfigLock)
		begin
			highEnable_nxt = cfgWrData[`ESMD_HIGH_BIT];
			segSize_nxt    = cfgWrData[`ESMD_SZ_HI:`ESMD_SZ_LO];
			segEnable_nxt  = cfgWrData[`ESMD_TEN_BIT];
		end
		if (wrHit && cfgWrData[`ESMD_ERR_BIT])
		begin
			errFlag_nxt = 1'b0;
		end
		if (hostValid && !hostMgmtMode && !mgmtOpen
			&& ((highOn && inHigh) || (segOn && inSeg)))
		begin
			errFlag_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			highEnable_r <= `ESMD_HIGH_RST;
			errFlag_r    <= `ESMD_ERR_RST;
			segSize_r    <= `ESMD_SZ_RST;
			segEnable_r  <= `ESMD_TEN_RST;
		end
		else
		begin
			highEnable_r <= highEnable_nxt;
			errFlag_r    <= errFlag_nxt;
			segSize_r    <= segSize_nxt;
			segEnable_r  <= segEnable_nxt;
		end
	end

	always_comb
	begin
		cfgRdData = 8'h00;
		if (cfgAddr == `ESMD_CTRL_OFS)
		begin
			cfgRdData = {highEnable_r, errFlag_r, 3'b000, segSize_r, segEnable_r}
				| `ESMD_FIXED_MASK;
		end
	end

	always_comb
	begin
		dramClaim  = 1'b0;
		hubForward = 1'b0;
		dramAddr   = hostAddr;
		if (hostValid)
		begin
			if (highOn && inHigh)
			begin
				dramClaim  = mgmtSees;
				hubForward = !mgmtSees;
				dramAddr   = `ESMD_LEGACY_BASE + (hostAddr - `ESMD_HIGH_BASE);
			end
			else if (segOn && inSeg)
			begin
				dramClaim  = mgmtSees;
				hubForward = !mgmtSees;
			end
			else if (segEnable_r && inSeg)
			begin
				hubForward = 1'b1;
			end
			else if (hostAddr < topOfMemory)
			begin
				dramClaim = 1'b1;
			end
			else
			begin
				hubForward = 1'b1;
			end
		end
	end

	a_err_sets: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && !hostMgmtMode && !mgmtOpen && highOn && inHigh
		|=> errFlag_r)
		else $error("error flag not set");

	a_err_seg: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && !hostMgmtMode && !mgmtOpen && segOn && inSeg
		|=> errFlag_r)
		else $error("error flag not set by segment access");

	a_err_cause: assert property (@(posedge core_clk) disable iff (!nrst)
		!errFlag_r && !(hostValid && !hostMgmtMode && !mgmtOpen)
		|=> !errFlag_r)
		else $error("error flag set without cause");

	a_err_clear: assert property (@(posedge core_clk) disable iff (!nrst)
		wrHit && cfgWrData[`ESMD_ERR_BIT] && !hostValid
		|=> !errFlag_r)
		else $error("error flag not cleared");

	a_zero_keeps: assert property (@(posedge core_clk) disable iff (!nrst)
		errFlag_r && !(wrHit && cfgWrData[`ESMD_ERR_BIT])
		|=> errFlag_r)
		else $error("error flag lost");

	a_fixed_ones: assert property (@(posedge core_clk) disable iff (!nrst)
		cfgAddr == `ESMD_CTRL_OFS
		|-> (cfgRdData & `ESMD_FIXED_MASK) == `ESMD_FIXED_MASK)
		else $error("fixed bits not one");

	a_read_other: assert property (@(posedge core_clk) disable iff (!nrst)
		cfgAddr != `ESMD_CTRL_OFS
		|-> cfgRdData == 8'h00)
		else $error("read outside register not zero");

	a_write_takes: assert property (@(posedge core_clk) disable iff (!nrst)
		wrHit && !mgmtConfigLock
		|=> highEnable_r == $past(cfgWrData[`ESMD_HIGH_BIT])
			&& segSize_r == $past(cfgWrData[`ESMD_SZ_HI:`ESMD_SZ_LO])
			&& segEnable_r == $past(cfgWrData[`ESMD_TEN_BIT]))
		else $error("unlocked write not taken");

	a_lock_holds: assert property (@(posedge core_clk) disable iff (!nrst)
		mgmtConfigLock && $past(mgmtConfigLock)
		|-> $stable({highEnable_r, segSize_r, segEnable_r}))
		else $error("locked field changed");

	a_high_remap: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && highOn && inHigh && hostMgmtMode
		|-> dramClaim && dramAddr >= `ESMD_LEGACY_BASE && dramAddr <= `ESMD_LEGACY_LAST)
		else $error("high remap wrong");

	a_gate_global: assert property (@(posedge core_clk) disable iff (!nrst)
		!globalMgmtMemEnable && hostValid && inHigh
		|-> dramAddr == hostAddr)
		else $error("remap without global enable");

	a_open_visible: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && highOn && inHigh && mgmtOpen && !mgmtConfigLock
		|-> dramClaim && !hubForward)
		else $error("open region not visible");

	a_lock_closes: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && highOn && inHigh && !hostMgmtMode && mgmtConfigLock
		|-> hubForward && !dramClaim)
		else $error("locked region visible outside management mode");

	a_seg_visible: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && segOn && inSeg && hostMgmtMode && !(highOn && inHigh)
		|-> dramClaim && dramAddr == hostAddr)
		else $error("segment not visible in management mode");

	a_seg_gate: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && !globalMgmtMemEnable && segEnable_r && inSeg
		|-> hubForward && !dramClaim)
		else $error("segment visible without global enable");

	a_seg_hidden: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && segEnable_r && inSeg && !(segOn && mgmtSees)
		|-> hubForward)
		else $error("segment claimed");

	a_seg_small: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && segEnable_r && segSize_r == 2'b00 && !(highOn && inHigh)
			&& topOfMemory >= `ESMD_SZ_1M
			&& hostAddr == topOfMemory - `ESMD_SZ_128K - 32'h0000_0001
		|-> dramClaim && !hubForward)
		else $error("smallest segment too large");

	a_seg_large: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && segEnable_r && segSize_r == 2'b11 && !(highOn && inHigh)
			&& !hostMgmtMode && !mgmtOpen && topOfMemory >= `ESMD_SZ_1M
			&& hostAddr == topOfMemory - `ESMD_SZ_1M
		|-> hubForward && !dramClaim)
		else $error("largest segment too small");

	a_fwd_above: assert property (@(posedge core_clk) disable iff (!nrst)
		hostValid && hostAddr >= topOfMemory && !(highOn && inHigh)
		|-> hubForward && !dramClaim)
		else $error("access above top of memory claimed");

	a_claim_excl: assert property (@(posedge core_clk) disable iff (!nrst)
		!(dramClaim && hubForward))
		else $error("claimed and forwarded at once");

	a_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
		!hostValid |-> !dramClaim && !hubForward)
		else $error("decode active without access");
endmodule

// file: verif/esmd_host_model.sv
`timescale 1ns/1ps
module esmd_host_model
(
	input  wire logic        core_clk,
	input  wire logic        reqValid,
	input  wire logic [31:0] reqAddr,
	input  wire logic        reqMode,
	output logic             hostValid,
	output logic      [31:0] hostAddr,
	output logic             hostMgmtMode
);
	// An idle bus inverts its address every cycle, alternating between its last address and the inverse.
	always_ff @(posedge core_clk)
	begin
		hostValid    <= reqValid;
		hostAddr     <= reqValid ? reqAddr : ~hostAddr;
		hostMgmtMode <= reqMode;
	end
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic        core_clk, nrst, cfgWrEn, g, lk, op, rv, rm, hostValid, hostMgmtMode, claim, fwd;
	logic [7:0]  cfgWrData, rd, d, ad;
	logic [31:0] ra, hostAddr, dramAddr, sz;
	int          errors, check_count;
	extended_smram_decode_control dut (.core_clk(core_clk), .nrst(nrst), .cfgWrEn(cfgWrEn),
		.cfgAddr(ad), .cfgWrData(cfgWrData), .cfgRdData(rd), .globalMgmtMemEnable(g),
		.mgmtConfigLock(lk), .mgmtOpen(op), .topOfMemory(32'h1000_0000),
		.hostValid(hostValid), .hostAddr(hostAddr), .hostMgmtMode(hostMgmtMode),
		.dramClaim(claim), .hubForward(fwd), .dramAddr(dramAddr));
	esmd_host_model host (.core_clk(core_clk), .reqValid(rv), .reqAddr(ra), .reqMode(rm),
		.hostValid(hostValid), .hostAddr(hostAddr), .hostMgmtMode(hostMgmtMode));
	function automatic logic [7:0] expReg(input logic [7:0] v, input logic e);
		return (v & 8'h87) | 8'h38 | {1'b0, e, 6'h00};
	endfunction
	task chkReg(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: register read %h expected %h", $time, got, exp);
		end
	endtask
	task chkDec(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: decode %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] v);
		@(posedge core_clk);
		cfgWrEn   <= 1'b1;
		cfgWrData <= v;
		@(posedge core_clk);
		cfgWrEn <= 1'b0;
		#1;
	endtask
	task acc(input logic [31:0] a, input logic m);
		@(posedge core_clk);
		rv <= 1'b1;
		ra <= a;
		rm <= m;
		@(posedge core_clk);
		rv <= 1'b0;
		#1;
	endtask
	task summarize;
		$display("Checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		{nrst, cfgWrEn, g, lk, op, rv, rm, cfgWrData, ra} = '0;
		ad = 8'h9E;
		errors = 0;
		check_count = 0;
		d = 8'($urandom(1507));
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		chkReg(rd, 8'h38);
		repeat (8)
		begin
			d = 8'($urandom);
			wr(d);
			chkReg(rd, expReg(d, 1'b0));
		end
		@(posedge core_clk);
		ad <= 8'h9D;
		wr(~d);
		chkReg(rd, 8'h00);
		@(posedge core_clk);
		ad <= 8'h9E;
		#1;
		chkReg(rd, expReg(d, 1'b0));
		$display("Test register writes done");
		wr(8'h81);
		acc(32'hFEDA_0010, 1'b1);
		chkDec({claim, fwd, dramAddr}, {2'b01, 32'hFEDA_0010});
		acc(32'h0FFE_0000, 1'b1);
		chkDec({claim, fwd, dramAddr}, {2'b01, 32'h0FFE_0000});
		@(posedge core_clk);
		g <= 1'b1;
		acc(32'hFEDA_0010, 1'b1);
		chkDec({claim, fwd, dramAddr}, {2'b10, 32'h000A_0010});
		acc(32'hFEDB_FFFF, 1'b0);
		chkDec({claim, fwd, 32'h0000_0000}, {2'b01, 32'h0000_0000});
		wr(8'h81);
		chkReg(rd, 8'hF9);
		wr(8'hC1);
		chkReg(rd, 8'hB9);
		$display("Test remap and error flag done");
		for (int s = 0; s < 4; s++)
		begin
			sz = 32'h0002_0000 << s;
			wr(8'h81 | 8'(s << 1));
			acc(32'h1000_0000 - sz, 1'b0);
			chkDec({claim, fwd, dramAddr}, {2'b01, 32'h1000_0000 - sz});
			acc(32'h1000_0000 - sz - 32'h0000_0001, 1'b0);
			chkDec({claim, fwd, dramAddr}, {2'b10, 32'h1000_0000 - sz - 32'h0000_0001});
			acc(32'h1000_0000 - sz, 1'b1);
			chkDec({claim, fwd, dramAddr}, {2'b10, 32'h1000_0000 - sz});
		end
		$display("Test top segment sizes done");
		@(posedge core_clk);
		lk <= 1'b1;
		wr(8'h00);
		chkReg(rd, 8'hFF);
		wr(8'h40);
		chkReg(rd, 8'hBF);
		$display("Test lock done");
		@(posedge core_clk);
		lk <= 1'b0;
		op <= 1'b1;
		wr(8'hC1);
		chkReg(rd, 8'hB9);
		acc(32'hFEDA_0000, 1'b0);
		chkDec({claim, fwd, dramAddr}, {2'b10, 32'h000A_0000});
		wr(8'h81);
		chkReg(rd, 8'hB9);
		@(posedge core_clk);
		lk <= 1'b1;
		acc(32'hFEDA_0000, 1'b0);
		chkDec({claim, fwd, 32'h0000_0000}, {2'b01, 32'h0000_0000});
		$display("Test open visibility done");
		@(posedge core_clk);
		lk <= 1'b0;
		op <= 1'b0;
		nrst <= 1'b0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		#1;
		chkReg(rd, 8'h38);
		acc(32'h0000_1000, 1'b0);
		chkDec({claim, fwd, dramAddr}, {2'b10, 32'h0000_1000});
		$display("Test reset done");
		summarize;
	end
endmodule
